/* File: rtl/rst_wdt_pkg.sv */
// constants shared by the reset and watchdog controller
//
// Contract
// - any reset forces I/O state; after release fetch starts at reset vector
// - port pins reset asynchronously when power-on, pin, brown-out or jtag source goes active, no clock needed
// - after all sources clear, fuse-selected delay counter stretches internal reset
// - exactly five sources: power-on, pin, watchdog, brown-out, jtag reset bit
// - pin low longer than minimum width resets even without clock
// - pin rising starts delay counter; release only after startup timeout
// - power-on threshold starts delay; supply falling reasserts reset at once
// - enabled brown-out asserts reset at once; clearing runs startup timeout
// - processor held in reset while jtag reset bit is one
// - watchdog reset only when enabled and period expires without restart
// - watchdog timeout gives one-cycle pulse; delay starts at its falling edge
// - watchdog counter runs from its own 1 MHz oscillator
// - watchdog counter cleared by restart, by disable and by chip reset
// - eight timeout periods chosen by timeout select field
// - safety fuse: unprogrammed level 1 disabled, programmed level 2 always on
// - level 1: writing enable bit to one enables anytime, no sequence
// - within four cycles write enable and select with unlock cleared; only then
// - level 2: watchdog always enabled, enable bit reads one
// - level 2: unlock write then select within four cycles; enable value ignored
// - bandgap enabled by brown-out fuse, comparator select or converter enable
// - select codes 0..7 give 16K to 2048K oscillator cycles
// - unlock bit cleared by hardware four cycles after being written
// - each source sets its own flag; cleared by power-on or writing zero
package rst_wdt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_WDT_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h01;
  // watchdog control fields
  localparam int BIT_UNLOCK = 4;
  localparam int BIT_ENABLE = 3;
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 3;
  // reset cause flag positions
  localparam int FLAG_POR = 0;
  localparam int FLAG_EXT = 1;
  localparam int FLAG_BROWNOUT = 2;
  localparam int FLAG_WDT = 3;
  localparam int FLAG_JTAG = 4;
  localparam int NUM_SRC = 5;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam int WDT_CNT_W = 22;
  localparam int WDT_BASE_LOG2 = 14;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [2:0] BROWNOUT_FUSE_OFF = 3'h7;
  // startup timeout base, scaled by fuses
  localparam int CLK_MHZ = 100;
  localparam int STARTUP_BASE_US = 65;
  localparam int STARTUP_BASE_CYCLES = STARTUP_BASE_US * CLK_MHZ;
  localparam int DELAY_W = 20;
  localparam int SYNC_W = 5;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_STRETCH = 3'b010,
    ST_RUN = 3'b100
  } rst_state_t;
endpackage : rst_wdt_pkg

/* File: rtl/reset_and_watchdog_control.sv */
// reset source merge, startup stretch, watchdog and bandgap enable
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module reset_and_watchdog_control
  import rst_wdt_pkg::*;
#(
  parameter int startup_base_cycles = STARTUP_BASE_CYCLES
) (
  input wire logic ref_clk, // system clock 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic por_ok, // power-on detector, high above threshold
  input wire logic ext_reset_n, // external reset pin
  input wire logic brownout_low, // brown-out comparator, high below trigger
  input wire logic jtag_reset_bit, // jtag reset register content
  input wire logic wdt_osc, // dedicated watchdog oscillator
  input wire logic [2:0] brownout_level_fuse, // all ones means detector off
  input wire logic [1:0] startup_time_fuse, // startup scaling
  input wire logic [3:0] clock_source_fuse, // bit 3 doubles startup delay
  input wire logic safety_level_fuse, // high when programmed
  input wire logic watchdog_restart_instruction, // one-cycle pulse from core
  input wire logic comparator_bandgap_select, // comparator uses bandgap
  input wire logic adc_enable, // converter enabled
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [DATA_W-1:0] rdata, // read data, cycle after rd
  output logic core_reset, // internal reset to core and registers
  output logic port_reset, // asynchronous port pin reset
  output logic fetch_start, // one-cycle pulse at reset release
  output logic [15:0] fetch_vector, // address of first fetch
  output logic bandgap_enable // bandgap reference enable
);

  // ********************************
  // input synchronisers
  // ********************************
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic osc_prev;
  assign raw_in = {wdt_osc, jtag_reset_bit, brownout_low, ~ext_reset_n, ~por_ok};

  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        sync1[i] <= raw_in[i];
        sync2[i] <= sync1[i];
      end
    end
  endgenerate

  wire brownout_on = (brownout_level_fuse != BROWNOUT_FUSE_OFF);
  wire por_src = sync2[0];
  wire ext_src = sync2[1];
  wire brownout_src = sync2[2] & brownout_on;
  wire jtag_src = sync2[3];
  wire osc_tick = sync2[4] & ~osc_prev;

  // ********************************
  // watchdog configuration
  // ********************************
  logic level2;
  logic wdt_en;
  logic [2:0] wdt_sel;
  logic unlock;
  logic [2:0] unlock_cnt;
  logic [WDT_CNT_W-1:0] wdt_cnt;
  logic wdt_fire;

  // timeout length in oscillator cycles, 16K << sel
  function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [2:0] sel);
    wdt_limit = WDT_CNT_W'(1) << (WDT_BASE_LOG2 + int'(sel));
  endfunction : wdt_limit

  wire wr_ctrl = wr & (addr == OFS_WDT_CTRL);
  wire wr_flags = wr & (addr == OFS_RESET_CAUSE);
  wire window_open = (unlock_cnt != 3'h0);
  wire wr_unlock = wr_ctrl & wdata[BIT_UNLOCK] & wdata[BIT_ENABLE];
  wire wr_change = wr_ctrl & ~wdata[BIT_UNLOCK] & window_open;
  wire en_eff = wdt_en | level2;
  wire wdt_expire = en_eff & osc_tick & (wdt_cnt == wdt_limit(wdt_sel) - WDT_CNT_W'(1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst || core_reset) begin
      level2 <= safety_level_fuse;
      wdt_en <= safety_level_fuse;
      wdt_sel <= SEL_RESET;
      unlock <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (wr_change) begin
      // timed update, enable ignored in level 2
      wdt_sel <= wdata[SEL_LSB +: SEL_W];
      wdt_en <= level2 | wdata[BIT_ENABLE];
      unlock <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (wr_unlock) begin
      wdt_en <= 1'b1;
      unlock <= 1'b1;
      unlock_cnt <= UNLOCK_CYCLES;
    end else begin
      // a bare enable write always sticks; clears and selects are dropped
      if (wr_ctrl && wdata[BIT_ENABLE]) begin
        wdt_en <= 1'b1;
      end
      if (window_open) begin
        unlock_cnt <= unlock_cnt - 3'h1;
      end
      if (unlock_cnt == 3'h1) begin
        unlock <= 1'b0;
      end
    end
  end

  // ********************************
  // watchdog counter
  // ********************************
  always_ff @(posedge ref_clk) begin
    osc_prev <= sync2[4];
    wdt_fire <= 1'b0;
    if (sys_rst || core_reset || !en_eff || watchdog_restart_instruction) begin
      wdt_cnt <= '0;
    end else if (wdt_expire) begin
      wdt_cnt <= '0;
      wdt_fire <= 1'b1;
    end else if (osc_tick) begin
      wdt_cnt <= wdt_cnt + WDT_CNT_W'(1);
    end
  end

  // ********************************
  // reset merge and stretch
  // ********************************
  // the watchdog pulse is a source too, so stretch begins after it falls
  wire any_src = por_src | ext_src | brownout_src | jtag_src | wdt_fire;
  wire [DELAY_W-1:0] base_cyc = DELAY_W'(startup_base_cycles);
  logic [DELAY_W-1:0] delay_len;
  logic [DELAY_W-1:0] delay_cnt;
  rst_state_t state;
  rst_state_t next_state;

  always_ff @(posedge ref_clk) begin
    if (core_reset) begin
      // fuses are treated as static and captured while held in reset
      delay_len <= (base_cyc << startup_time_fuse) << clock_source_fuse[3];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_HOLD: begin
        if (!any_src) begin
          next_state = ST_STRETCH;
        end
      end
      ST_STRETCH: begin
        if (any_src) begin
          next_state = ST_HOLD;
        end else if (delay_cnt == delay_len - DELAY_W'(1)) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_src) begin
          next_state = ST_HOLD;
        end
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
      delay_cnt <= '0;
    end else begin
      state <= next_state;
      delay_cnt <= (state == ST_STRETCH && !any_src) ? delay_cnt + DELAY_W'(1) : '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_reset <= 1'b1;
      fetch_start <= 1'b0;
      fetch_vector <= RESET_VECTOR;
    end else begin
      core_reset <= (next_state != ST_RUN);
      fetch_start <= (state != ST_RUN) && (next_state == ST_RUN);
      fetch_vector <= RESET_VECTOR;
    end
  end

  // ports drop to their reset state without waiting for a clock edge, except on a watchdog reset
  wire async_src = ~por_ok | ~ext_reset_n | (brownout_low & brownout_on) | jtag_reset_bit;
  always_ff @(posedge ref_clk or posedge async_src) begin
    if (async_src) begin
      port_reset <= 1'b1;
    end else begin
      port_reset <= sys_rst | core_reset;
    end
  end

  // ********************************
  // reset cause flags and bus
  // ********************************
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] set_flags;
  assign set_flags[FLAG_POR] = por_src;
  assign set_flags[FLAG_EXT] = ext_src;
  assign set_flags[FLAG_BROWNOUT] = brownout_src;
  assign set_flags[FLAG_WDT] = wdt_fire;
  assign set_flags[FLAG_JTAG] = jtag_src;
  wire [NUM_SRC-1:0] keep_mask = wr_flags ? wdata[NUM_SRC-1:0] : {NUM_SRC{1'b1}};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags <= FLAGS_RESET;
    end else if (por_src) begin
      flags <= 5'h01 << FLAG_POR;
    end else begin
      // a set in the same cycle as a clear wins
      flags <= (flags & keep_mask) | set_flags;
    end
  end

  wire [DATA_W-1:0] ctrl_view = {3'h0, unlock, en_eff, wdt_sel};
  wire [DATA_W-1:0] rd_mux = (addr == OFS_WDT_CTRL) ? ctrl_view :
                             (addr == OFS_RESET_CAUSE) ? {3'h0, flags} : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata <= 8'h00;
      bandgap_enable <= 1'b0;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
      bandgap_enable <= brownout_on | comparator_bandgap_select | adc_enable;
    end
  end

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_fire_one;
    wdt_fire |=> !wdt_fire;
  endproperty
  a_fire_one: assert property (p_fire_one) else $error("watchdog pulse longer than one cycle");

  property p_fire_holds;
    wdt_fire |-> ##[1:2] core_reset;
  endproperty
  a_fire_holds: assert property (p_fire_holds) else $error("watchdog timeout did not reset");

  property p_level2_on;
    level2 && !core_reset |-> wdt_en && ctrl_view[BIT_ENABLE];
  endproperty
  a_level2_on: assert property (p_level2_on) else $error("level 2 enable reads zero");

  property p_unlock_close;
    wr_unlock && !core_reset ##1 (!wr_ctrl && !core_reset) [*4] |=> !unlock;
  endproperty
  a_unlock_close: assert property (p_unlock_close) else $error("unlock not cleared after four cycles");

  property p_locked_sel;
    wr_ctrl && !window_open && !core_reset |=> $stable(wdt_sel);
  endproperty
  a_locked_sel: assert property (p_locked_sel) else $error("select changed outside window");

  property p_bandgap;
    comparator_bandgap_select |=> bandgap_enable;
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap off while comparator needs it");

  property p_jtag_hold;
    jtag_src |=> core_reset;
  endproperty
  a_jtag_hold: assert property (p_jtag_hold) else $error("jtag reset did not hold core");

  property p_restart_clear;
    watchdog_restart_instruction |=> (wdt_cnt == '0) && !wdt_fire;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart left counter running");

  property p_flag_set;
    ext_src |=> flags[FLAG_EXT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("pin reset flag not set");

  property p_stretch_min;
    $fell(core_reset) |-> $past(state == ST_STRETCH);
  endproperty
  a_stretch_min: assert property (p_stretch_min) else $error("release without startup stretch");

  property p_fetch_vec;
    fetch_start |-> !core_reset && (fetch_vector == RESET_VECTOR);
  endproperty
  a_fetch_vec: assert property (p_fetch_vec) else $error("fetch started while held or off vector");

  property p_fire_enabled;
    wdt_fire |-> $past(en_eff);
  endproperty
  a_fire_enabled: assert property (p_fire_enabled) else $error("watchdog fired while disabled");

  property p_port_follow;
    core_reset |=> port_reset;
  endproperty
  a_port_follow: assert property (p_port_follow) else $error("port pins released while core held");

  property p_por_fast;
    por_src |=> core_reset;
  endproperty
  a_por_fast: assert property (p_por_fast) else $error("supply drop did not reassert reset");

  property p_brownout_fast;
    brownout_src |=> core_reset;
  endproperty
  a_brownout_fast: assert property (p_brownout_fast) else $error("brown-out did not assert reset");

  property p_pin_hold;
    ext_src |=> core_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("reset pin low did not hold core");

  property p_stretch_bound;
    state == ST_STRETCH |-> delay_cnt < delay_len;
  endproperty
  a_stretch_bound: assert property (p_stretch_bound) else $error("stretch counter ran past its length");

  property p_flag_por;
    por_src |=> flags == (5'h01 << FLAG_POR);
  endproperty
  a_flag_por: assert property (p_flag_por) else $error("power-on did not leave only its own flag");

  property p_bandgap_off;
    !brownout_on && !comparator_bandgap_select && !adc_enable |=> !bandgap_enable;
  endproperty
  a_bandgap_off: assert property (p_bandgap_off) else $error("bandgap on with no user");

  c_release: cover property (fetch_start);
  c_wdt_reset: cover property (wdt_fire ##1 core_reset);
  c_timed_change: cover property (wr_unlock ##[1:4] wr_change);
  c_reassert: cover property (state == ST_STRETCH ##1 state == ST_HOLD);

endmodule : reset_and_watchdog_control
`default_nettype wire

/* File: sim/supply_and_pin_model.sv */
// supply detectors, reset pin, jtag bit and watchdog oscillator
`timescale 1ns/1ns
`default_nettype none
module supply_and_pin_model (
  input wire logic supply_low, // supply below power-on level
  input wire logic brownout, // supply below brown-out trigger
  input wire logic pin_low, // reset pin pulled low
  input wire logic jtag_hold, // jtag reset register holds one
  output logic por_ok, // power-on detector
  output logic ext_reset_n, // reset pin level
  output logic brownout_low, // brown-out comparator
  output logic jtag_reset_bit, // jtag reset register content
  output logic wdt_osc // dedicated watchdog oscillator
);
  // analog levels land off the clock grid, like real detectors
  assign #3 por_ok = !supply_low;
  assign #3 ext_reset_n = !pin_low;
  assign #3 brownout_low = brownout;
  assign #3 jtag_reset_bit = jtag_hold;
  // 30 ns period keeps the shortest timeout under 50k system cycles
  initial begin
    wdt_osc = 1'b0;
    #7;
    forever #15 wdt_osc = !wdt_osc;
  end
endmodule : supply_and_pin_model
`default_nettype wire

/* File: sim/reset_and_watchdog_control_bench.sv */
// self-checking bench for the reset and watchdog controller
`timescale 1ns/1ns
`default_nettype none
module reset_and_watchdog_control_bench;
  import rst_wdt_pkg::*;
  typedef struct packed {logic cmp_bg; logic adc; logic [7:0] addr; logic bg; logic [7:0] rd;} row_t;
  logic ref_clk, sys_rst, supply_low, brownout, pin_low, jtag_hold, safety_level_fuse, restart;
  logic cmp_bg, adc, wr, rd, core_reset, port_reset, fetch_start, bandgap_enable;
  logic [2:0] brownout_level_fuse;
  logic [1:0] startup_time_fuse;
  logic [3:0] clock_source_fuse;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic [15:0] fetch_vector;
  wire por_ok, ext_reset_n, brownout_low, jtag_reset_bit, wdt_osc;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  row_t rows [4] = '{'{1'b0, 1'b0, 8'h00, 1'b0, 8'h00}, '{1'b1, 1'b0, 8'h01, 1'b1, 8'h00},
                     '{1'b0, 1'b1, 8'h02, 1'b1, 8'h00}, '{1'b1, 1'b1, 8'hff, 1'b1, 8'h00}};

  supply_and_pin_model far_side (.supply_low(supply_low), .brownout(brownout), .pin_low(pin_low),
    .jtag_hold(jtag_hold), .por_ok(por_ok), .ext_reset_n(ext_reset_n), .brownout_low(brownout_low),
    .jtag_reset_bit(jtag_reset_bit), .wdt_osc(wdt_osc));

  reset_and_watchdog_control #(.startup_base_cycles(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .por_ok(por_ok), .ext_reset_n(ext_reset_n), .brownout_low(brownout_low), .jtag_reset_bit(jtag_reset_bit),
    .wdt_osc(wdt_osc), .brownout_level_fuse(brownout_level_fuse), .startup_time_fuse(startup_time_fuse),
    .clock_source_fuse(clock_source_fuse), .safety_level_fuse(safety_level_fuse),
    .watchdog_restart_instruction(restart),
    .comparator_bandgap_select(cmp_bg), .adc_enable(adc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .core_reset(core_reset), .port_reset(port_reset), .fetch_start(fetch_start),
    .fetch_vector(fetch_vector), .bandgap_enable(bandgap_enable));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    reg_rd(a, rd_val);
    check(rd_val, exp);
  endtask : expect_reg

  // stretch length plus two sync stages, small slack for the async edge
  task automatic wait_release(input int len);
    n = 0;
    while (core_reset !== 1'b0 && n < 60) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n >= len && n <= len + 6, 1'b1);
    check(fetch_start, 1'b1);
    check(fetch_vector, RESET_VECTOR);
  endtask : wait_release

  task automatic do_reset(input logic [2:0] bo_fuse, input logic level2, input int len);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    brownout_level_fuse <= bo_fuse;
    safety_level_fuse <= level2;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check(core_reset, 1'b1);
    check(port_reset, 1'b1);
    wait_release(len);
  endtask : do_reset

  task automatic hit_source(input int idx);
    @(posedge ref_clk);
    case (idx)
      0: supply_low <= 1'b1;
      1: pin_low <= 1'b1;
      2: brownout <= 1'b1;
      default: jtag_hold <= 1'b1;
    endcase
    #5;
    check(port_reset, 1'b1);
    repeat (4) @(posedge ref_clk);
    #1;
    check(core_reset, 1'b1);
    repeat (12) @(posedge ref_clk);
    check(core_reset, 1'b1);
    {supply_low, pin_low, brownout, jtag_hold} <= 4'h0;
    wait_release(8);
    expect_reg(OFS_RESET_CAUSE, 8'h01 << (idx == 3 ? 4 : idx));
    reg_wr(OFS_RESET_CAUSE, 8'h00);
    expect_reg(OFS_RESET_CAUSE, 8'h00);
  endtask : hit_source

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end

  initial begin
    // the tests need about 80k cycles; a hang is caught before 100k
    #950000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    {supply_low, pin_low, brownout, jtag_hold, restart, cmp_bg, adc, wr, rd} = 9'h000;
    brownout_level_fuse = 3'h7;
    startup_time_fuse = 2'h0;
    clock_source_fuse = 4'h0;
    safety_level_fuse = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    do_reset(3'h7, 1'b0, 8);
    reg_wr(8'h02, 8'hff);
    reg_wr(8'hff, 8'h1f);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      cmp_bg <= rows[i].cmp_bg;
      adc <= rows[i].adc;
      reg_rd(rows[i].addr, rd_val);
      check(bandgap_enable, rows[i].bg);
      check(rd_val, rows[i].rd);
    end
    reg_wr(OFS_WDT_CTRL, 8'h08);
    expect_reg(OFS_WDT_CTRL, 8'h08);
    reg_wr(OFS_WDT_CTRL, 8'h00);
    expect_reg(OFS_WDT_CTRL, 8'h08);
    reg_wr(OFS_WDT_CTRL, 8'h18);
    reg_wr(OFS_WDT_CTRL, 8'h01);
    expect_reg(OFS_WDT_CTRL, 8'h01);
    reg_wr(OFS_WDT_CTRL, 8'h18);
    repeat (5) @(posedge ref_clk);
    expect_reg(OFS_WDT_CTRL, 8'h09);
    reg_wr(OFS_WDT_CTRL, 8'h02);
    expect_reg(OFS_WDT_CTRL, 8'h09);
    reg_wr(OFS_WDT_CTRL, 8'h18);
    reg_wr(OFS_WDT_CTRL, 8'h08);
    // restart halfway: 60k cycles without a fire proves the count was cleared
    repeat (30000) @(posedge ref_clk);
    restart <= 1'b1;
    @(posedge ref_clk);
    restart <= 1'b0;
    repeat (30000) @(posedge ref_clk);
    check(core_reset, 1'b0);
    n = 0;
    while (core_reset !== 1'b1 && n < 25000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(core_reset, 1'b1);
    wait_release(8);
    expect_reg(OFS_RESET_CAUSE, 8'h08);
    expect_reg(OFS_WDT_CTRL, 8'h00);
    do_reset(3'h0, 1'b1, 8);
    expect_reg(OFS_WDT_CTRL, 8'h08);
    reg_wr(OFS_WDT_CTRL, 8'h00);
    expect_reg(OFS_WDT_CTRL, 8'h08);
    reg_wr(OFS_WDT_CTRL, 8'h18);
    reg_wr(OFS_WDT_CTRL, 8'h03);
    expect_reg(OFS_WDT_CTRL, 8'h0b);
    cmp_bg <= 1'b0;
    adc <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(bandgap_enable, 1'b1);
    for (int s = 0; s < 4; s++) begin
      hit_source(s);
    end
    // fuse-selected stretch: base of 8 shifted by the startup fuse, doubled by clock fuse bit 3
    @(posedge ref_clk);
    startup_time_fuse <= 2'h1;
    clock_source_fuse <= 4'h8;
    do_reset(3'h7, 1'b0, 32);
    expect_reg(OFS_WDT_CTRL, 8'h00);
    print_verdict();
  end
endmodule : reset_and_watchdog_control_bench
`default_nettype wire
